/* txoh_pkg.sv */
`timescale 1ns/1ps
package txoh_pkg;

    typedef enum logic [2:0]
    {
        TXOH_DIRECT,
        TXOH_PLCP,
        TXOH_HDLC,
        TXOH_PPP,
        TXOH_CLEAR
    } txoh_mode_t;

    // ***************************************************************
    // Register map (byte addresses)
    // ***************************************************************
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_MSG      = 8'h08;
    localparam logic [7:0] REG_COUNT    = 8'h0C;
    localparam logic [7:0] REG_POH_BASE = 8'h10;

    localparam int          CTRL_MODE_LSB   = 0;
    localparam int          STAT_POH_LSB    = 0;
    localparam int          STAT_FRAME_LSB  = 16;
    localparam int          MSG_FIRST_POS   = 8;
    localparam txoh_mode_t  MODE_RESET      = TXOH_DIRECT;

    // ***************************************************************
    // Link timing: output clocks are the link clock divided by four
    // ***************************************************************
    localparam logic [1:0] RISE_PHASE     = 2'h1;
    localparam logic [1:0] TAKE_PHASE     = 2'h3;
    localparam logic [6:0] POH_FRAME_BITS = 7'h60;
    localparam logic [3:0] POH_BYTES      = 4'hC;
    localparam int         PIN_W          = 11;

endpackage

module txoh_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    typedef struct packed
    {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } txoh_sync_t;

    txoh_sync_t s_q;
    txoh_sync_t s_d;

    // First stage feeds only the second
    always_comb
    begin
        s_d.meta = i_d;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign o_q = s_q.sync;
endmodule // txoh_sync

/* txoh_port.sv */
`timescale 1ns/1ps
module txoh_port
    import txoh_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_link_clk,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_path_overhead_serial_in,
    input  wire logic        i_overhead_insert_request,
    output logic             o_overhead_insert_clock,
    output logic             o_overhead_frame_marker,
    input  wire logic        i_message_send_request,
    input  wire logic [7:0]  i_message_byte_bus,
    output logic             o_message_byte_clock,
    output logic      [7:0]  o_hdlc_byte,
    output logic             o_hdlc_valid,
    output logic             o_hdlc_sof,
    output logic             o_hdlc_eof
);

    // ***************************************************************
    // Link domain
    // ***************************************************************
    typedef struct packed
    {
        logic [1:0] cnt;
        logic       ohclk;
        logic       mbclk;
        logic       mark;
        logic [6:0] pos;
        logic       full;
        logic [7:0] shreg;
        logic [7:0] poh_hold;
        logic [3:0] poh_idx;
        logic       poh_tgl;
        logic [7:0] msg_hold;
        logic       msg_first;
        logic       msg_tgl;
        logic       in_frame;
        logic       end_tgl;
        logic [2:0] mode_seen;
        txoh_mode_t mode;
    } txoh_link_t;

    txoh_link_t        ln_q;
    txoh_link_t        ln_d;
    logic [PIN_W-1:0]  pins_l;
    logic [2:0]        mode_raw_l;
    txoh_mode_t        mode_l;
    logic              plcp_l;
    logic              hdlc_l;
    logic              bit_l;
    logic              req_l;
    logic              send_l;
    logic [7:0]        bus_l;
    logic              take;
    logic              send;
    logic [2:0]        mode_c;

    // Pins are timed to our own output clock but still land on two flops
    txoh_sync #(.W(PIN_W)) u_pin_sync
    (
        .i_clk (i_link_clk),
        .i_rst (i_rst),
        .i_d   ({i_message_byte_bus, i_message_send_request,
                 i_overhead_insert_request, i_path_overhead_serial_in}),
        .o_q   (pins_l)
    );

    // Mode is a quasi-static level; software changes it while idle
    txoh_sync #(.W(3)) u_mode_sync
    (
        .i_clk (i_link_clk),
        .i_rst (i_rst),
        .i_d   (mode_c),
        .o_q   (mode_raw_l)
    );

    assign mode_l = ln_q.mode;
    assign plcp_l = (mode_l == TXOH_PLCP);
    assign hdlc_l = (mode_l == TXOH_HDLC);
    assign bit_l  = pins_l[0];
    assign req_l  = pins_l[1];
    assign send_l = pins_l[2];
    assign bus_l  = pins_l[10:3];
    // Synced copy of the rise-edge sample is ready two edges later
    assign take   = (ln_q.cnt == TAKE_PHASE);
    assign send   = hdlc_l & send_l;

    always_comb
    begin
        ln_d     = ln_q;
        ln_d.cnt = ln_q.cnt + 2'h1;
        if (!plcp_l)
        begin
            ln_d.pos  = 7'h00;
            ln_d.full = 1'b0;
        end
        else if (take)
        begin
            if (ln_q.pos[2:0] == 3'h0)
                ln_d.full = req_l;
            else
                ln_d.full = ln_q.full & req_l;
            if (req_l)
                ln_d.shreg = {ln_q.shreg[6:0], bit_l};
            if ((ln_q.pos[2:0] == 3'h7) && ln_d.full)
            begin
                ln_d.poh_hold = {ln_q.shreg[6:0], bit_l};
                ln_d.poh_idx  = ln_q.pos[6:3];
                ln_d.poh_tgl  = ~ln_q.poh_tgl;
            end
            if (ln_q.pos == POH_FRAME_BITS - 7'h01)
                ln_d.pos = 7'h00;
            else
                ln_d.pos = ln_q.pos + 7'h01;
        end
        // Mode word taken only when two samples agree, so a half-moved
        // word never acts; taken at a period end so first pulses are full
        ln_d.mode_seen = mode_raw_l;
        if (take && (mode_raw_l == ln_q.mode_seen))
            ln_d.mode = txoh_mode_t'(mode_raw_l);
        ln_d.mark  = (ln_d.mode == TXOH_PLCP)
                     && (ln_d.pos == 7'h00);
        ln_d.ohclk = (ln_d.mode == TXOH_PLCP) & ln_d.cnt[1];
        ln_d.mbclk = (ln_d.mode == TXOH_HDLC) & ln_d.cnt[1];
        if (take)
        begin
            if (send)
            begin
                ln_d.msg_hold  = bus_l;
                ln_d.msg_first = ~ln_q.in_frame;
                ln_d.in_frame  = 1'b1;
                ln_d.msg_tgl   = ~ln_q.msg_tgl;
            end
            else if (ln_q.in_frame)
            begin
                ln_d.in_frame = 1'b0;
                ln_d.end_tgl  = ~ln_q.end_tgl;
            end
        end
    end

    always_ff @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ln_q      <= '0;
            ln_q.mode <= MODE_RESET;
        end
        else
            ln_q <= ln_d;
    end

    assign o_overhead_insert_clock = ln_q.ohclk;
    assign o_message_byte_clock    = ln_q.mbclk;
    assign o_overhead_frame_marker = ln_q.mark;

    // ***************************************************************
    // Link assertions
    // ***************************************************************
    a_poh_serial_in: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        (take && plcp_l && ln_q.pos[2:0] == 3'h7 && ln_d.full)
        |=> ln_q.poh_hold == {$past(ln_q.shreg[6:0]), $past(bit_l)}
            && $changed(ln_q.poh_tgl))
        else $error("overhead byte not delivered");
    a_poh_needs_req: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        (take && plcp_l && !req_l) |=> $stable(ln_q.shreg))
        else $error("overhead bit taken without request");
    a_poh_bit_sample: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        (take && plcp_l && req_l) |=> ln_q.shreg[0] == $past(bit_l))
        else $error("overhead bit not sampled");
    a_direct_ignored: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        (mode_l == TXOH_DIRECT) |=> ln_q.pos == 7'h00
            && $stable(ln_q.poh_tgl))
        else $error("overhead port active in direct mode");
    a_msg_capture: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        (take && send) |=> ln_q.msg_hold == $past(bus_l)
            && $changed(ln_q.msg_tgl))
        else $error("message byte not captured");
    a_frame_close: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        (take && !send && ln_q.in_frame)
        |=> $changed(ln_q.end_tgl) && !ln_q.in_frame)
        else $error("frame not closed on request fall");
    a_msg_stop: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        (take && !send_l) |=> $stable(ln_q.msg_tgl))
        else $error("byte captured with request low");
    a_ppp_ignored: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        (mode_l == TXOH_PPP) |=> $stable(ln_q.msg_tgl)
            && !o_message_byte_clock)
        else $error("send request honoured in ppp mode");
    a_marker_width: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        ($rose(o_overhead_frame_marker) && plcp_l && $past(plcp_l))
        |-> (o_overhead_frame_marker && plcp_l)[*4]
            ##1 (!o_overhead_frame_marker || !$past(plcp_l)))
        else $error("marker not one overhead clock wide");
    a_marker_gate: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        !plcp_l |-> !o_overhead_frame_marker)
        else $error("marker outside plcp mode");
    a_ohclk_runs: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        (plcp_l && ln_q.cnt == RISE_PHASE) |=> o_overhead_insert_clock
            ##2 !o_overhead_insert_clock)
        else $error("overhead clock stalled");
    a_msb_line: assert property (@(posedge i_link_clk)
        disable iff (i_rst)
        (take && send) |=> ln_q.msg_hold[7] == $past(bus_l[7]))
        else $error("message msb misplaced");

    // ***************************************************************
    // Core domain: register slave and event collection
    // ***************************************************************
    typedef struct packed
    {
        logic                  ack;
        logic [31:0]           rdata;
        txoh_mode_t            mode;
        logic [2:0]            seen;
        logic [7:0]            last_msg;
        logic                  last_first;
        logic [15:0]           byte_cnt;
        logic [15:0]           frame_cnt;
        logic [15:0]           poh_cnt;
        logic [11:0][7:0]      poh_mem;
        logic [7:0]            hbyte;
        logic                  hvalid;
        logic                  hsof;
        logic                  heof;
    } txoh_core_t;

    txoh_core_t  cr_q;
    txoh_core_t  cr_d;
    logic [2:0]  tgl_c;
    logic        req_c;
    logic [5:0]  widx;
    logic [5:0]  poff;
    logic [3:0]  pidx;

    // Toggles cross; held link data is stable for four link cycles
    txoh_sync #(.W(3)) u_evt_sync
    (
        .i_clk (i_core_clk),
        .i_rst (i_rst),
        .i_d   ({ln_q.end_tgl, ln_q.msg_tgl, ln_q.poh_tgl}),
        .o_q   (tgl_c)
    );

    assign mode_c = cr_q.mode;
    assign req_c  = i_avs_read | i_avs_write;
    assign widx   = i_avs_address[7:2];
    assign poff   = widx - REG_POH_BASE[7:2];
    assign pidx   = poff[3:0];
    assign o_avs_waitrequest = req_c & ~cr_q.ack;

    always_comb
    begin
        cr_d        = cr_q;
        cr_d.ack    = req_c & ~cr_q.ack;
        cr_d.seen   = tgl_c;
        cr_d.hvalid = 1'b0;
        cr_d.hsof   = 1'b0;
        cr_d.heof   = 1'b0;
        cr_d.rdata  = 32'h0000_0000;
        case (i_avs_address)
            REG_CTRL:
                cr_d.rdata[CTRL_MODE_LSB +: 3] = cr_q.mode;
            REG_STATUS:
            begin
                cr_d.rdata[STAT_POH_LSB +: 16]   = cr_q.poh_cnt;
                cr_d.rdata[STAT_FRAME_LSB +: 16] = cr_q.frame_cnt;
            end
            REG_MSG:
                cr_d.rdata[MSG_FIRST_POS:0] = {cr_q.last_first,
                                               cr_q.last_msg};
            REG_COUNT:
                cr_d.rdata[15:0] = cr_q.byte_cnt;
            default:
                // Judged on the full word offset, else high words alias
                if (i_avs_address[1:0] == 2'h0
                    && widx >= REG_POH_BASE[7:2]
                    && poff < {2'h0, POH_BYTES})
                    cr_d.rdata[7:0] = cr_q.poh_mem[pidx];
        endcase
        if (i_avs_write && cr_q.ack && i_avs_address == REG_CTRL)
            cr_d.mode = txoh_mode_t'(i_avs_writedata[CTRL_MODE_LSB +: 3]);
        if (tgl_c[0] != cr_q.seen[0])
        begin
            if (ln_q.poh_idx < POH_BYTES)
                cr_d.poh_mem[ln_q.poh_idx] = ln_q.poh_hold;
            cr_d.poh_cnt = cr_q.poh_cnt + 16'h0001;
        end
        if (tgl_c[1] != cr_q.seen[1])
        begin
            cr_d.last_msg   = ln_q.msg_hold;
            cr_d.last_first = ln_q.msg_first;
            cr_d.hbyte      = ln_q.msg_hold;
            cr_d.hvalid     = 1'b1;
            cr_d.hsof       = ln_q.msg_first;
            cr_d.byte_cnt   = ln_q.msg_first ? 16'h0001
                                             : cr_q.byte_cnt + 16'h0001;
        end
        if (tgl_c[2] != cr_q.seen[2])
        begin
            cr_d.heof      = 1'b1;
            cr_d.frame_cnt = cr_q.frame_cnt + 16'h0001;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cr_q      <= '0;
            cr_q.mode <= MODE_RESET;
        end
        else
            cr_q <= cr_d;
    end

    assign o_avs_readdata = cr_q.rdata;
    assign o_hdlc_byte    = cr_q.hbyte;
    assign o_hdlc_valid   = cr_q.hvalid;
    assign o_hdlc_sof     = cr_q.hsof;
    assign o_hdlc_eof     = cr_q.heof;

endmodule // txoh_port

/* txoh_term.sv */
`timescale 1ns/1ps
module txoh_term (
    input  wire logic        i_rst,
    input  wire logic        i_link_clk,
    input  wire logic        i_poh_clk,
    input  wire logic        i_marker,
    input  wire logic        i_poh_en,
    input  wire logic        i_msg_clk,
    input  wire logic [15:0] i_msg_target,
    output logic             o_poh_bit,
    output logic             o_poh_req,
    output logic             o_msg_req,
    output logic      [7:0]  o_msg_bus
);
    // ***************************************************************
    // Terminal feeding overhead bits and message bytes
    // ***************************************************************
    logic [6:0]  bit_idx;
    logic [15:0] sent;
    logic [7:0]  cur;
    logic        poh_seen;
    logic        msg_seen;

    // Byte k of a frame carries A0+k, MSB first
    assign cur       = 8'hA0 + {4'h0, bit_idx[6:3]};
    assign o_poh_bit = cur[3'h7 - bit_idx[2:0]];
    assign o_poh_req = i_poh_en;

    // Edges seen one link cycle late, so marker and clocks are settled
    always @(posedge i_link_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            poh_seen  <= 1'b0;
            msg_seen  <= 1'b0;
            bit_idx   <= 7'h0;
            sent      <= 16'h0;
            o_msg_req <= 1'b0;
            o_msg_bus <= 8'h00;
        end
        else
        begin
            poh_seen <= i_poh_clk;
            msg_seen <= i_msg_clk;
            if (i_poh_clk && !poh_seen && i_marker)
                bit_idx <= 7'h1;
            else if (i_poh_clk && !poh_seen)
                bit_idx <= (bit_idx == 7'h5F) ? 7'h0 : bit_idx + 7'h1;
            if (i_msg_clk && !msg_seen && sent != i_msg_target)
            begin
                o_msg_req <= 1'b1;
                o_msg_bus <= 8'h80 + sent[7:0];
                sent      <= sent + 16'h1;
            end
            else if (i_msg_clk && !msg_seen)
            begin
                o_msg_req <= 1'b0;
                o_msg_bus <= ~o_msg_bus;
            end
        end
    end
endmodule // txoh_term

/* txoh_port_bench.sv */
`timescale 1ns/1ps
module txoh_port_bench
    import txoh_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        link_clk = 1'b1;
    logic        rst, av_rd, av_wr, av_wait, poh_bit, poh_req, poh_en;
    logic        oh_clk, oh_mark, msg_req, msg_clk, hd_valid, hd_sof, hd_eof;
    logic [7:0]  av_addr, msg_bus, hd_byte;
    logic [31:0] av_wdata, av_rdata, rd_val;
    logic [15:0] msg_target;
    logic [8:0]  got_q[$];
    int          err_total, check_count, mk_cnt, oh_rises, eof_cnt, n_got;

    always #20 core_clk = ~core_clk;
    always #24 link_clk = ~link_clk;

    txoh_port dut (.i_core_clk(core_clk), .i_rst(rst), .i_link_clk(link_clk),
        .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
        .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata),
        .o_avs_waitrequest(av_wait), .i_path_overhead_serial_in(poh_bit),
        .i_overhead_insert_request(poh_req), .o_overhead_insert_clock(oh_clk),
        .o_overhead_frame_marker(oh_mark), .i_message_send_request(msg_req),
        .i_message_byte_bus(msg_bus), .o_message_byte_clock(msg_clk),
        .o_hdlc_byte(hd_byte), .o_hdlc_valid(hd_valid), .o_hdlc_sof(hd_sof),
        .o_hdlc_eof(hd_eof));

    txoh_term term (.i_rst(rst), .i_link_clk(link_clk), .i_poh_clk(oh_clk),
        .i_marker(oh_mark), .i_poh_en(poh_en), .i_msg_clk(msg_clk),
        .i_msg_target(msg_target), .o_poh_bit(poh_bit), .o_poh_req(poh_req),
        .o_msg_req(msg_req), .o_msg_bus(msg_bus));

    // ***************************************************************
    // Monitors
    // ***************************************************************
    always @(posedge core_clk)
    begin
        if (hd_valid === 1'b1)
            got_q.push_back({hd_sof, hd_byte});
        if (hd_eof === 1'b1)
            eof_cnt++;
    end
    always @(posedge oh_mark) mk_cnt++;
    always @(posedge oh_clk) oh_rises++;

    // ***************************************************************
    // Tasks
    // ***************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    // One Avalon access; waits for waitrequest low under a bound
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge core_clk);
        av_addr  <= a;
        av_wdata <= d;
        av_wr    <= wr;
        av_rd    <= ~wr;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (av_wait !== 1'b0 && n < 50);
        rd_val = av_rdata;
        if (av_wait !== 1'b0)
            err_total++;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd_val, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Mode needs a few link cycles to reach the link side
    task automatic set_mode(input txoh_mode_t m);
        bus(1'b1, REG_CTRL, {29'h0, m});
        idle(20);
    endtask

    task automatic poh_all(input logic filled);
        for (int k = 0; k < 12; k++)
            rd_chk(REG_POH_BASE + 8'(4 * k),
                   filled ? {24'h0, 8'hA0 + 8'(k)} : 32'h0);
    endtask

    task automatic wait_eof(input int k);
        int n;
        n = 0;
        while (eof_cnt < k && n < 3000)
        begin
            @(posedge core_clk);
            n++;
        end
        if (eof_cnt < k)
            err_total++;
    endtask

    task print_verdict;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        #1000000;
        err_total++;
        print_verdict();
    end

    // ***************************************************************
    // Tests
    // ***************************************************************
    initial
    begin
        rst = 1'b1;
        av_addr = 8'h00;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_wdata = 32'h0;
        poh_en = 1'b0;
        msg_target = 16'h0;
        err_total = 0;
        check_count = 0;
        mk_cnt = 0;
        oh_rises = 0;
        eof_cnt = 0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(REG_CTRL, {29'h0, MODE_RESET});
        bus(1'b1, REG_STATUS, 32'hFFFF_FFFF);
        rd_chk(REG_STATUS, 32'h0);
        rd_chk(8'hF0, 32'h0);
        // Direct-mapped with request high: pins must stay ignored
        poh_en <= 1'b1;
        idle(500);
        poh_all(1'b0);
        chk(mk_cnt, 0);
        poh_en <= 1'b0;
        set_mode(TXOH_PLCP);
        oh_rises = 0;
        idle(600);
        chk(32'(oh_rises > 100), 32'h1);
        chk(32'(mk_cnt > 0), 32'h1);
        poh_all(1'b0);
        // Three frames so at least two are marker aligned
        poh_en <= 1'b1;
        idle(1400);
        poh_all(1'b1);
        rd_chk(8'hF0, 32'h0);
        poh_en <= 1'b0;
        // Shortest frame first, then a five byte frame
        set_mode(TXOH_HDLC);
        mk_cnt = 0;
        msg_target <= 16'h1;
        wait_eof(1);
        msg_target <= 16'h6;
        wait_eof(2);
        chk(eof_cnt, 2);
        chk(got_q.size(), 6);
        foreach (got_q[i])
            chk({23'h0, got_q[i]}, {23'h0, i < 2, 8'(8'h80 + i)});
        bus(1'b0, REG_STATUS, 32'h0);
        chk({16'h0, rd_val[31:16]}, 32'h2);
        rd_chk(REG_COUNT, 32'h5);
        rd_chk(REG_MSG, 32'h85);
        // Request left high across the switch: PPP must ignore it
        msg_target <= 16'h40;
        idle(20);
        chk(msg_req, 32'h1);
        set_mode(TXOH_PPP);
        n_got = got_q.size();
        idle(300);
        chk(32'(n_got > 6), 32'h1);
        chk(got_q.size(), n_got);
        chk(msg_req, 32'h1);
        chk(eof_cnt, 3);
        set_mode(TXOH_CLEAR);
        idle(300);
        chk(mk_cnt, 0);
        print_verdict();
    end
endmodule // txoh_port_bench
